//--- verilog/scp_top.sv
// Serial configuration port: slave frames on the link clock, EEPROM load as
// master on the system clock, register storage in scp_reg_mem.
// Assumes the testbench resolves each pin from the output enables.
//
// Functional notes
// - Source select high: master loads from EEPROM
// - EEPROM data sampled on clock falling edge
// - Reset puts serial pins in high impedance
// - EEPROM only read, never written or erased
// - Shift input only while select is high
// - Select low commits write to addressed register
// - Frame: flag, 7 address, 16 data, MSB first
// - Arbitrary pauses between bits allowed
// - Edges after the 24th are ignored
// - Read frame: address only, data on output
// - Reset reloads registers from selected source
// - Slave writes may overwrite loaded registers
`timescale 1ns/1ps
`include "scp_params.svh"

module scp_top #(
    parameter int AW = `SCP_ADDR_BITS,
    parameter int DW = `SCP_DATA_BITS,
    parameter int LOAD_WORDS = `SCP_LOAD_WORDS,
    parameter int MW_AW = `SCP_MW_ADDR_BITS,
    parameter int MW_HALF = `SCP_MW_HALF
) (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic config_source_select,
    input wire logic serial_clk,
    input wire logic serial_select,
    input wire logic serial_data_in,
    output logic serial_data_out,
    output logic serial_data_out_oe,
    output logic master_clk_out,
    output logic master_clk_oe,
    output logic master_select_out,
    output logic master_select_oe,
    output logic master_data_out,
    output logic master_data_oe,
    input wire logic [AW-1:0] core_rd_addr,
    output logic [DW-1:0] core_rd_data,
    output logic load_done
);

    // ****************************************
    // Synchronisers into the system clock
    // ****************************************
    logic src_s1, src_s2, sel_s1, sel_s2, sel_s3, din_s1, din_s2;
    logic rreq_s1, rreq_s2, rreq_s3;
    logic rd_req_toggle;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            src_s1 <= 1'b0;
            src_s2 <= 1'b0;
            sel_s1 <= 1'b0;
            sel_s2 <= 1'b0;
            sel_s3 <= 1'b0;
            din_s1 <= 1'b0;
            din_s2 <= 1'b0;
            rreq_s1 <= 1'b0;
            rreq_s2 <= 1'b0;
            rreq_s3 <= 1'b0;
        end else begin
            src_s1 <= config_source_select;
            src_s2 <= src_s1;
            sel_s1 <= serial_select;
            sel_s2 <= sel_s1;
            sel_s3 <= sel_s2;
            din_s1 <= serial_data_in;
            din_s2 <= din_s1;
            rreq_s1 <= rd_req_toggle;
            rreq_s2 <= rreq_s1;
            rreq_s3 <= rreq_s2;
        end
    end

    // ****************************************
    // Sequencer and EEPROM master
    // ****************************************
    scp_pkg::scp_state_t state;
    logic [AW-1:0] init_addr;
    logic [AW-1:0] word_idx;
    logic [15:0] half_cnt;
    logic [4:0] edge_no;
    logic [8:0] mw_cmd;
    logic [DW-1:0] mw_data;
    logic master_active;
    logic half_done;

    assign half_done = (half_cnt == 16'(MW_HALF - 1));

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            state <= scp_pkg::SCP_INIT;
            init_addr <= '0;
            word_idx <= '0;
            half_cnt <= '0;
            edge_no <= '0;
            mw_cmd <= '0;
            mw_data <= '0;
            master_active <= 1'b0;
            master_clk_out <= 1'b0;
            master_select_out <= 1'b0;
            master_data_out <= 1'b0;
            master_clk_oe <= 1'b0;
            master_select_oe <= 1'b0;
            master_data_oe <= 1'b0;
            load_done <= 1'b0;
        end else begin
            case (state)
                scp_pkg::SCP_INIT: begin
                    init_addr <= init_addr + 1'b1;
                    if (init_addr == {AW{1'b1}}) begin
                        if (src_s2) begin
                            state <= scp_pkg::SCP_GAP;
                            master_active <= 1'b1;
                            master_clk_oe <= 1'b1;
                            master_select_oe <= 1'b1;
                            master_data_oe <= 1'b1;
                        end else begin
                            state <= scp_pkg::SCP_RUN;
                            load_done <= 1'b1;
                        end
                    end
                end
                scp_pkg::SCP_GAP: begin
                    master_select_out <= 1'b0;
                    master_clk_out <= 1'b0;
                    half_cnt <= half_done ? '0 : half_cnt + 1'b1;
                    if (half_done) begin
                        if (word_idx == AW'(LOAD_WORDS)) begin
                            state <= scp_pkg::SCP_RUN;
                            master_active <= 1'b0;
                            master_clk_oe <= 1'b0;
                            master_select_oe <= 1'b0;
                            master_data_oe <= 1'b0;
                            load_done <= 1'b1;
                        end else begin
                            // only the read opcode is issued
                            state <= scp_pkg::SCP_XFER;
                            master_select_out <= 1'b1;
                            mw_cmd <= {`SCP_MW_READ_OP, word_idx[MW_AW-1:0]};
                            master_data_out <= 1'b1;
                            edge_no <= '0;
                        end
                    end
                end
                scp_pkg::SCP_XFER: begin
                    half_cnt <= half_done ? '0 : half_cnt + 1'b1;
                    if (half_done && !master_clk_out) begin
                        master_clk_out <= 1'b1;
                    end else if (half_done) begin
                        master_clk_out <= 1'b0;
                        edge_no <= edge_no + 1'b1;
                        mw_cmd <= {mw_cmd[7:0], 1'b0};
                        master_data_out <= (edge_no + 1'b1 < `SCP_MW_CMD_BITS) ? mw_cmd[7] : 1'b0;
                        // EEPROM bit taken at the falling edge
                        if (edge_no + 1'b1 >= `SCP_MW_DATA_FIRST) begin
                            mw_data <= {mw_data[DW-2:0], din_s2};
                        end
                        if (edge_no + 1'b1 == `SCP_MW_CLOCKS) begin
                            state <= scp_pkg::SCP_GAP;
                            word_idx <= word_idx + 1'b1;
                        end
                    end
                end
                default: begin
                    state <= scp_pkg::SCP_RUN;
                end
            endcase
        end
    end

    // ****************************************
    // Link side: frame reception
    // ****************************************
    logic link_clr;
    logic [4:0] bit_cnt;
    logic [23:0] hold;
    logic [AW-1:0] link_rd_addr;
    logic wr_ok;

    // pins released under reset and while mastering
    assign link_clr = sys_rst | ~serial_select | master_active;

    always_ff @(posedge serial_clk or posedge link_clr) begin
        if (link_clr) begin
            bit_cnt <= '0;
        // count saturates at the 24th edge
        end else if (bit_cnt != `SCP_FRAME_BITS) begin
            bit_cnt <= bit_cnt + 1'b1;
        end
    end

    always_ff @(posedge serial_clk or posedge sys_rst) begin
        if (sys_rst) begin
            hold <= '0;
            link_rd_addr <= '0;
            rd_req_toggle <= 1'b0;
            wr_ok <= 1'b0;
        end else if (serial_select && !master_active && bit_cnt != `SCP_FRAME_BITS) begin
            // shifting only while select is high
            hold <= {hold[22:0], serial_data_in};
            if (bit_cnt == '0) begin
                wr_ok <= 1'b0;
            end
            // address complete, fetch for a read
            if (bit_cnt == `SCP_ADDR_DONE_CNT) begin
                link_rd_addr <= {hold[5:0], serial_data_in};
                if (hold[6]) begin
                    rd_req_toggle <= ~rd_req_toggle;
                end
            end
            // full frame with write flag zero
            if (bit_cnt == `SCP_FLAG_LAST_CNT) begin
                wr_ok <= ~hold[22];
            end
        end
    end

    // ****************************************
    // Link side: read data out
    // ****************************************
    logic [DW-1:0] slave_rd_data;
    logic [DW-1:0] out_sh;

    always_ff @(negedge serial_clk or posedge link_clr) begin
        if (link_clr) begin
            out_sh <= '0;
            serial_data_out <= 1'b0;
            serial_data_out_oe <= 1'b0;
        // flag one reads, MSB after falling edge
        end else if (bit_cnt == `SCP_RD_LOAD_CNT && hold[8] && !serial_data_out_oe) begin
            out_sh <= {slave_rd_data[DW-2:0], 1'b0};
            serial_data_out <= slave_rd_data[DW-1];
            serial_data_out_oe <= 1'b1;
        end else if (serial_data_out_oe) begin
            out_sh <= {out_sh[DW-2:0], 1'b0};
            serial_data_out <= out_sh[DW-1];
        end
    end

    // ****************************************
    // Register storage access
    // ****************************************
    logic next_we;
    logic [AW-1:0] next_waddr;
    logic [DW-1:0] next_wdata;
    logic rd_fire;

    assign rd_fire = (state == scp_pkg::SCP_RUN) && (rreq_s2 != rreq_s3);

    always_comb begin
        next_we = 1'b0;
        next_waddr = init_addr;
        next_wdata = '0;
        if (state == scp_pkg::SCP_INIT) begin
            next_we = 1'b1;
            if (init_addr == `SCP_FAULT_ADDR) begin
                next_wdata = `SCP_FAULT_RST;
            end
        end else if (state == scp_pkg::SCP_GAP && half_cnt == '0 && word_idx != '0
                     && master_active) begin
            // upper four bits of each word dropped
            next_we = 1'b1;
            next_waddr = word_idx - 1'b1;
            next_wdata = mw_data & `SCP_KEEP_MASK;
        end else if (state == scp_pkg::SCP_RUN && !sel_s2 && sel_s3 && wr_ok) begin
            // commit on select low; any time later
            next_we = 1'b1;
            next_waddr = hold[22:16];
            next_wdata = hold[15:0];
        end
    end

    scp_reg_mem #(
        .AW(AW),
        .DW(DW)
    ) u_mem (
        .clk(sys_clk),
        .rst(sys_rst),
        .wr_en(next_we),
        .wr_addr(next_waddr),
        .wr_data(next_wdata),
        .rd_en_a(rd_fire),
        .rd_addr_a(link_rd_addr),
        .rd_data_a(slave_rd_data),
        .rd_addr_b(core_rd_addr),
        .rd_data_b(core_rd_data)
    );

endmodule : scp_top

//--- verilog/scp_params.svh
// Constants of the serial configuration port: frame layout, register map
// sizes, reset values and EEPROM read command.
// Assumes inclusion by bare name from the design files.
`ifndef SCP_PARAMS_SVH
`define SCP_PARAMS_SVH

`define SCP_FRAME_BITS 5'h18
`define SCP_ADDR_BITS 7
`define SCP_DATA_BITS 16
`define SCP_LOAD_WORDS 12
`define SCP_FAULT_ADDR 7'h2A
`define SCP_FAULT_RST 16'h0018
`define SCP_KEEP_MASK 16'h0FFF
`define SCP_ADDR_DONE_CNT 5'h07
`define SCP_FLAG_LAST_CNT 5'h17
`define SCP_RD_LOAD_CNT 5'h09
`define SCP_MW_ADDR_BITS 6
`define SCP_MW_READ_OP 3'h6
`define SCP_MW_CMD_BITS 5'h09
`define SCP_MW_DATA_FIRST 5'h0A
`define SCP_MW_CLOCKS 5'h19
`define SCP_MW_HALF 25

`endif

//--- verilog/scp_pkg.sv
// Types of the serial configuration port.
// Assumes nothing beyond a SystemVerilog compiler.
package scp_pkg;

    // Control sequencer of the system-clock side
    typedef enum logic [3:0] {
        SCP_INIT = 4'b0001,
        SCP_XFER = 4'b0010,
        SCP_GAP = 4'b0100,
        SCP_RUN = 4'b1000
    } scp_state_t;

endpackage : scp_pkg

//--- verilog/scp_reg_mem.sv
// Register storage: one write port, two read ports with registered data.
// Assumes a single clock; reads return data one edge after the address.
`timescale 1ns/1ps

module scp_reg_mem #(
    parameter int AW = 7,
    parameter int DW = 16
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_addr,
    input wire logic [DW-1:0] wr_data,
    input wire logic rd_en_a,
    input wire logic [AW-1:0] rd_addr_a,
    output logic [DW-1:0] rd_data_a,
    input wire logic [AW-1:0] rd_addr_b,
    output logic [DW-1:0] rd_data_b
);

    logic [DW-1:0] mem [0:(1<<AW)-1];

    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rd_data_a <= '0;
            rd_data_b <= '0;
        end else begin
            if (rd_en_a) begin
                rd_data_a <= mem[rd_addr_a];
            end
            rd_data_b <= mem[rd_addr_b];
        end
    end

endmodule : scp_reg_mem

//--- test/scp_eeprom_model.sv
// Microwire EEPROM model holding 16-bit words, read commands only.
// Assumes clock, select and data from the device master pins.
`timescale 1ns/1ps
module scp_eeprom_model (
    input wire logic rst,
    input wire logic cs,
    input wire logic sk,
    input wire logic di,
    output logic dout,
    output int bad
);
    // ********************
    // Command decode
    // ********************
    logic [8:0] cmd = 9'h000;
    logic [15:0] word = 16'h0000;
    logic [5:0] nxt = 6'h00;
    int cnt = 0;
    initial dout = 1'b0;
    initial bad = 0;
    always @(posedge rst) nxt = 6'h00;
    // Released line shows the inverse of its last value
    always @(negedge cs) begin
        cnt = 0;
        dout = ~dout;
    end
    always @(posedge sk) begin
        if (cs) begin
            cnt = cnt + 1;
            if (cnt <= 9) cmd = {cmd[7:0], di};
            // read opcode, upward words, top nibble set
            if (cnt == 9) begin
                if (cmd[8:6] !== 3'b110 || cmd[5:0] !== nxt) bad = bad + 1;
                word = {10'h3D4, cmd[5:0]};
                nxt = nxt + 6'h01;
            end else if (cnt >= 10 && cnt <= 25) dout = word[25 - cnt];
        end
    end
endmodule : scp_eeprom_model

//--- test/scp_top_sva.sv
// Checker on the ports of scp_top.
// Assumes MW_HALF of 4 in the bench and a stable strap while running.
`timescale 1ns/1ps
module scp_top_sva (
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic config_source_select,
    input wire logic serial_clk,
    input wire logic serial_select,
    input wire logic serial_data_out_oe,
    input wire logic master_clk_out,
    input wire logic master_clk_oe,
    input wire logic master_select_out,
    input wire logic master_select_oe,
    input wire logic master_data_oe,
    input wire logic load_done
);
    // ********************
    // Assertions
    // ********************
    logic [4:0] rise_cnt;
    always_ff @(posedge serial_clk or negedge serial_select) begin
        if (!serial_select) rise_cnt <= 5'h00;
        else if (rise_cnt != 5'h1F) rise_cnt <= rise_cnt + 5'h01;
    end
    rst_hiz_a: assert property (@(posedge sys_clk) sys_rst |-> !(serial_data_out_oe
        || master_clk_oe || master_select_oe || master_data_oe)) else $error("pins driven in reset");
    oe_excl_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        !(serial_data_out_oe && master_data_oe)) else $error("both data drivers on");
    master_strap_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        master_select_oe |-> config_source_select) else $error("master without strap");
    idle_done_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        load_done |-> !master_select_out) else $error("master busy after load");
    done_hold_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        load_done |=> load_done) else $error("load done dropped");
    clk_in_cs_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        master_clk_out |-> master_select_out) else $error("master clock outside select");
    half_period_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        $rose(master_clk_out) |-> master_clk_out [*4] ##1 !master_clk_out)
        else $error("master clock high time wrong");
    oe_select_a: assert property (@(posedge sys_clk) disable iff (sys_rst)
        serial_data_out_oe |-> serial_select) else $error("output on without select");
    read_start_a: assert property (@(posedge serial_clk) disable iff (sys_rst)
        $rose(serial_data_out_oe) |-> rise_cnt == 5'h09) else $error("read data started late");
    cover property (@(posedge sys_clk) $rose(load_done) && config_source_select);
    cover property (@(posedge sys_clk) $rose(serial_data_out_oe));
    cover property (@(posedge sys_clk) $rose(master_select_out));
endmodule : scp_top_sva
bind scp_top scp_top_sva chk_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .config_source_select(config_source_select), .serial_clk(serial_clk),
    .serial_select(serial_select), .serial_data_out_oe(serial_data_out_oe),
    .master_clk_out(master_clk_out), .master_clk_oe(master_clk_oe),
    .master_select_out(master_select_out), .master_select_oe(master_select_oe),
    .master_data_oe(master_data_oe), .load_done(load_done));

//--- test/scp_top_tb_top.sv
// Testbench of scp_top: host frames, EEPROM load, core reads.
// Assumes the EEPROM model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module scp_top_tb_top;
    // ********************
    // Pins and instances
    // ********************
    logic sys_clk = 1'b0;
    logic sys_rst;
    logic strap = 1'b0;
    logic h_sck = 1'b0;
    logic h_sel = 1'b0;
    logic h_sdi = 1'b0;
    logic [6:0] rd_addr = 7'h00;
    logic [15:0] rd_data, got;
    logic sdo, sdo_oe, mck, mck_oe, mcs, mcs_oe, mdo, mdo_oe, done, ee_do;
    wire logic pin_sck = mck_oe ? mck : h_sck;
    wire logic pin_sel = mcs_oe ? mcs : h_sel;
    wire logic pin_din = mcs_oe ? ee_do : h_sdi;
    int err_total = 0;
    int comparisons = 0;
    int cycles = 0;
    int ee_bad;
    always #10 sys_clk = ~sys_clk;
    scp_top #(.MW_HALF(4)) dut_u (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .config_source_select(strap), .serial_clk(pin_sck), .serial_select(pin_sel),
        .serial_data_in(pin_din), .serial_data_out(sdo), .serial_data_out_oe(sdo_oe),
        .master_clk_out(mck), .master_clk_oe(mck_oe), .master_select_out(mcs),
        .master_select_oe(mcs_oe), .master_data_out(mdo), .master_data_oe(mdo_oe),
        .core_rd_addr(rd_addr), .core_rd_data(rd_data), .load_done(done));
    scp_eeprom_model ee_u (.rst(sys_rst), .cs(mcs_oe & mcs), .sk(pin_sck), .di(mdo),
        .dout(ee_do), .bad(ee_bad));
    // ********************
    // Shared tasks
    // ********************
    task print_verdict;
        if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : print_verdict
    task chk16(input logic [15:0] g, input logic [15:0] e);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk16
    task core_rd(input logic [6:0] a, output logic [15:0] d);
        @(posedge sys_clk) rd_addr <= a;
        repeat (2) @(posedge sys_clk);
        #1 d = rd_data;
    endtask : core_rd
    task frame(input logic [23:0] w, input int n, output logic [15:0] d);
        d = 16'h0000;
        h_sel <= 1'b1;
        #7;
        for (int i = 1; i <= n; i++) begin
            h_sdi <= (i <= 24) ? w[24 - i] : 1'b0;
            #40 h_sck <= 1'b1;
            #80 h_sck <= 1'b0;
            #40 if (i >= 9 && i <= 24) d[24 - i] = sdo;
            if (i % 8 == 0) #900;
        end
        h_sel <= 1'b0;
        h_sdi <= ~h_sdi;
        repeat (8) @(posedge sys_clk);
    endtask : frame
    task do_reset(input logic s);
        @(posedge sys_clk) sys_rst <= 1'b1;
        strap <= s;
        repeat (3) @(posedge sys_clk);
        chk16({12'h000, sdo_oe, mck_oe, mcs_oe, mdo_oe}, 16'h0000);
        sys_rst <= 1'b0;
        for (int k = 0; k < 6000 && done !== 1'b1; k++) @(posedge sys_clk);
        chk16({15'h0000, done}, 16'h0001);
    endtask : do_reset
    // ********************
    // Scenarios
    // ********************
    task t_defaults;
        core_rd(7'h2A, got);
        chk16(got, 16'h0018);
        core_rd(7'h05, got);
        chk16(got, 16'h0000);
    endtask : t_defaults
    task t_write_read;
        frame({1'b0, 7'h05, 16'h1234}, 26, got);
        core_rd(7'h05, got);
        chk16(got, 16'h1234);
        frame({1'b1, 7'h05, 16'hFFFF}, 24, got);
        chk16(got, 16'h1234);
        core_rd(7'h05, got);
        chk16(got, 16'h1234);
    endtask : t_write_read
    task t_short;
        frame({1'b0, 7'h06, 16'hABCD}, 12, got);
        core_rd(7'h06, got);
        chk16(got, 16'h0000);
    endtask : t_short
    task t_eeprom;
        do_reset(1'b1);
        for (int a = 0; a < 12; a++) begin
            core_rd(7'(a), got);
            chk16(got, {10'h014, 6'(a)});
        end
        chk16(16'(ee_bad), 16'h0000);
    endtask : t_eeprom
    task t_overwrite;
        frame({1'b0, 7'h03, 16'hBEEF}, 24, got);
        core_rd(7'h03, got);
        chk16(got, 16'hBEEF);
        do_reset(1'b0);
        core_rd(7'h03, got);
        chk16(got, 16'h0000);
    endtask : t_overwrite
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 40000) begin
            err_total++;
            print_verdict;
        end
    end
    initial begin
        sys_rst <= 1'b1;
        do_reset(1'b0);
        t_defaults;
        t_write_read;
        t_short;
        t_eeprom;
        t_overwrite;
        print_verdict;
    end
endmodule : scp_top_tb_top
